// ### include/pwb_pkg.sv
// Constants, register map and state types of the nine-channel PWM block
package pwb_pkg;
  // Channel count and per-channel register window
  localparam int CH_N = 9;
  localparam logic [3:0] CH_LAST = 4'h8;
  // Per-channel register offsets within the channel window
  localparam logic [7:0] OFF_CTL = 8'h00;
  localparam logic [7:0] OFF_STEP = 8'h04;
  localparam logic [7:0] OFF_RAMP = 8'h08;
  localparam logic [7:0] OFF_HIGH = 8'h0c;
  localparam logic [7:0] OFF_LOW = 8'h10;
  localparam logic [7:0] OFF_PERIOD = 8'h14;
  localparam logic [7:0] OFF_ACTIVE = 8'h18;
  // Shared FIFO group, full byte addresses
  localparam logic [11:0] OFF_FIFO_CTL = 12'hf00;
  localparam logic [11:0] OFF_FIFO_WORD = 12'hf04;
  localparam logic [11:0] OFF_FIFO_STAT = 12'hf08;
  // channel_control fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_POL_BIT = 2;
  localparam int CTL_ON_BIT = 3;
  localparam int CTL_RUN_BIT = 4;
  // breath_ramp_rates fields
  localparam int RAMP_UP_LSB = 0;
  localparam int RAMP_DN_LSB = 16;
  // fifo_path_control fields
  localparam int FPC_START_BIT = 0;
  localparam int FPC_SEL_LSB = 4;
  // fifo_condition fields
  localparam int FST_ERR_BIT = 0;
  localparam int FST_FULL_BIT = 1;
  localparam int FST_EMPTY_BIT = 2;
  localparam int FST_LVL_LSB = 3;
  // Reset values
  localparam logic [4:0] RST_CTL = 5'h00;
  localparam logic [7:0] RST_STEP = 8'h20;
  localparam logic [15:0] RST_PERIOD = 16'h0001;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [1:0] RST_FIFO_LVL = 2'h2;
  // FIFO depth: the level field counts free slots, two when empty
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  // Channel modes
  typedef enum logic [1:0] {
    PWB_FIXED = 2'b00,
    PWB_BREATH = 2'b01,
    PWB_PROG = 2'b10,
    PWB_RSVD = 2'b11
  } pwb_mode_t;
  // Breath phases
  typedef enum logic [1:0] {
    PWB_RISE = 2'b00,
    PWB_HOLD_HI = 2'b01,
    PWB_FALL = 2'b10,
    PWB_HOLD_LO = 2'b11
  } pwb_phase_t;
endpackage

// ### rtl/pwb_top.sv
// Nine-channel PWM with fixed, breath and FIFO-fed programmable modes
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module pwb_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dma_valid,
  input wire logic [15:0] dma_data,
  output logic dma_ready,
  output logic [8:0] pwm_out
);

  // Merge write data into an old value under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bus decode
  logic [3:0] ch_sel; // Channel window addressed
  logic [7:0] ch_off; // Offset inside the window
  logic rd_ack_r; // Read answered this cycle
  logic [31:0] rd_data_r; // Registered read data
  logic [31:0] rd_mux; // Combinational read selection
  logic [31:0] ch_rdata [pwb_pkg::CH_N]; // Per-channel readback

  assign ch_sel = avs_address[11:8];
  assign ch_off = avs_address[7:0];

  // Shared FIFO state
  logic start_r; // DMA fill enable
  logic [3:0] fsel_r; // Channel owning the FIFO
  logic err_r; // Sticky FIFO error
  logic [15:0] fmem_r [2]; // Two-entry word store
  logic wptr_r; // Write slot
  logic rptr_r; // Read slot
  logic [1:0] fcnt_r; // Words held
  logic f_empty; // No word held
  logic f_full; // No slot free
  logic f_push; // Word accepted from DMA
  logic f_pop; // Word consumed by owner
  logic [15:0] f_head; // Oldest word
  logic [8:0] want_pop; // Owner reached a period boundary

  assign f_empty = (fcnt_r == 2'h0);
  assign f_full = (fcnt_r == pwb_pkg::FIFO_DEPTH);
  assign f_head = f_empty ? 16'h0000 : fmem_r[rptr_r];
  // Back-pressure: DMA is stalled while disabled or full
  assign dma_ready = start_r & ~f_full;
  assign f_push = dma_valid & dma_ready;
  assign f_pop = (|want_pop) & ~f_empty;

  // Reads take one wait cycle so read data comes from a flop
  assign avs_waitrequest = avs_read & ~rd_ack_r;
  assign avs_readdata = rd_data_r;

  // Read acknowledge and data capture
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_ack_r <= 1'b0;
      rd_data_r <= 32'h0000_0000;
    end else begin
      rd_ack_r <= avs_read & ~rd_ack_r;
      if (avs_read & ~rd_ack_r) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  // Read selection; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ch_sel <= pwb_pkg::CH_LAST) begin
      rd_mux = ch_rdata[ch_sel];
    end else if (avs_address == pwb_pkg::OFF_FIFO_CTL) begin
      rd_mux[pwb_pkg::FPC_START_BIT] = start_r;
      rd_mux[pwb_pkg::FPC_SEL_LSB +: 4] = fsel_r;
    end else if (avs_address == pwb_pkg::OFF_FIFO_WORD) begin
      rd_mux[15:0] = f_head;
    end else if (avs_address == pwb_pkg::OFF_FIFO_STAT) begin
      rd_mux[pwb_pkg::FST_ERR_BIT] = err_r;
      rd_mux[pwb_pkg::FST_FULL_BIT] = f_full;
      rd_mux[pwb_pkg::FST_EMPTY_BIT] = f_empty;
      rd_mux[pwb_pkg::FST_LVL_LSB +: 2] =
        pwb_pkg::FIFO_DEPTH - fcnt_r; // Level counts free slots
    end
  end

  // FIFO path control register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      start_r <= 1'b0;
      fsel_r <= 4'h0;
    end else if (avs_write && avs_address == pwb_pkg::OFF_FIFO_CTL) begin
      if (avs_byteenable[0]) begin
        start_r <= avs_writedata[pwb_pkg::FPC_START_BIT];
        fsel_r <= avs_writedata[pwb_pkg::FPC_SEL_LSB +: 4];
      end
    end
  end

  // Error flag: underrun sets it, write one clears, set wins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      err_r <= 1'b0;
    end else if ((|want_pop) & f_empty) begin
      err_r <= 1'b1;
    end else if (avs_write && avs_address == pwb_pkg::OFF_FIFO_STAT &&
                 avs_byteenable[0] &&
                 avs_writedata[pwb_pkg::FST_ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  // FIFO pointers and storage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      fcnt_r <= 2'h0;
      fmem_r[0] <= 16'h0000;
      fmem_r[1] <= 16'h0000;
    end else begin
      if (f_push) begin
        fmem_r[wptr_r] <= dma_data;
        wptr_r <= ~wptr_r;
      end
      if (f_pop) begin
        rptr_r <= ~rptr_r;
      end
      if (f_push & ~f_pop) begin
        fcnt_r <= fcnt_r + 2'h1;
      end else if (f_pop & ~f_push) begin
        fcnt_r <= fcnt_r - 2'h1;
      end
    end
  end

  // One independent channel per iteration
  for (genvar gi = 0; gi < pwb_pkg::CH_N; gi++) begin : g_ch
    logic [4:0] ctl_r; // Mode, polarity, enable, run
    logic [7:0] step_r; // Breath step count C
    logic [7:0] up_r; // Ramp-up rate
    logic [7:0] dn_r; // Ramp-down rate
    logic [15:0] hi_r; // High hold in waves
    logic [15:0] lo_r; // Low hold in waves
    logic [15:0] per_r; // Period count
    logic [15:0] act_r; // Fixed active count
    logic wr_ch; // Write aimed at this channel
    logic [31:0] rd_v; // Readback word
    pwb_pkg::pwb_mode_t mode; // Decoded mode
    logic pol; // Active level
    logic on; // Channel enable
    logic run; // Channel run request
    logic running_r; // Waveform in progress
    logic [15:0] cnt_r; // Position inside the period
    logic [15:0] top; // Clocks per period
    logic [15:0] top_m1; // Last count of the period
    logic wrap; // Period boundary
    logic [15:0] duty_r; // Latched duty for fixed and FIFO modes
    pwb_pkg::pwb_phase_t phase_r; // Breath phase
    logic [7:0] lvl_r; // Breath duty level
    logic [15:0] rep_r; // Waves spent on this level
    logic [15:0] lim; // Waves allowed on this level
    logic last; // Final wave of this level
    logic [15:0] duty_now; // Duty used this period
    logic active; // Inside the active part
    logic out_r; // Registered pin level

    assign wr_ch = avs_write & (ch_sel == 4'(gi));
    assign mode = pwb_pkg::pwb_mode_t'(ctl_r[pwb_pkg::CTL_MODE_LSB +: 2]);
    assign pol = ctl_r[pwb_pkg::CTL_POL_BIT];
    assign on = ctl_r[pwb_pkg::CTL_ON_BIT];
    assign run = ctl_r[pwb_pkg::CTL_RUN_BIT];

    // Configuration registers
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        ctl_r <= pwb_pkg::RST_CTL;
        step_r <= pwb_pkg::RST_STEP;
        up_r <= 8'h00;
        dn_r <= 8'h00;
        hi_r <= pwb_pkg::RST_ZERO16;
        lo_r <= pwb_pkg::RST_ZERO16;
        per_r <= pwb_pkg::RST_PERIOD;
        act_r <= pwb_pkg::RST_ZERO16;
      end else if (wr_ch) begin
        unique case (ch_off)
          pwb_pkg::OFF_CTL:
            ctl_r <= 5'(be_merge({27'h0, ctl_r}, avs_writedata,
                                 avs_byteenable));
          pwb_pkg::OFF_STEP:
            step_r <= 8'(be_merge({24'h0, step_r}, avs_writedata,
                                  avs_byteenable));
          pwb_pkg::OFF_RAMP: begin
            if (avs_byteenable[0]) begin
              up_r <= avs_writedata[pwb_pkg::RAMP_UP_LSB +: 8];
            end
            if (avs_byteenable[2]) begin
              dn_r <= avs_writedata[pwb_pkg::RAMP_DN_LSB +: 8];
            end
          end
          pwb_pkg::OFF_HIGH:
            hi_r <= 16'(be_merge({16'h0, hi_r}, avs_writedata,
                                 avs_byteenable));
          pwb_pkg::OFF_LOW:
            lo_r <= 16'(be_merge({16'h0, lo_r}, avs_writedata,
                                 avs_byteenable));
          pwb_pkg::OFF_PERIOD:
            per_r <= 16'(be_merge({16'h0, per_r}, avs_writedata,
                                  avs_byteenable));
          pwb_pkg::OFF_ACTIVE:
            act_r <= 16'(be_merge({16'h0, act_r}, avs_writedata,
                                  avs_byteenable));
          default: begin
            // Holes in the window ignore writes
          end
        endcase
      end
    end

    // Readback of this channel's window; holes read zero
    always_comb begin
      rd_v = 32'h0000_0000;
      unique case (ch_off)
        pwb_pkg::OFF_CTL: rd_v[4:0] = ctl_r;
        pwb_pkg::OFF_STEP: rd_v[7:0] = step_r;
        pwb_pkg::OFF_RAMP: begin
          rd_v[pwb_pkg::RAMP_UP_LSB +: 8] = up_r;
          rd_v[pwb_pkg::RAMP_DN_LSB +: 8] = dn_r;
        end
        pwb_pkg::OFF_HIGH: rd_v[15:0] = hi_r;
        pwb_pkg::OFF_LOW: rd_v[15:0] = lo_r;
        pwb_pkg::OFF_PERIOD: rd_v[15:0] = per_r;
        pwb_pkg::OFF_ACTIVE: rd_v[15:0] = act_r;
        default: rd_v = 32'h0000_0000;
      endcase
    end
    assign ch_rdata[gi] = rd_v;

    // Breath waves are C clocks long, other modes the period count
    assign top = (mode == pwb_pkg::PWB_BREATH) ? {8'h00, step_r} : per_r;
    // A zero count would never wrap, so it acts as one
    assign top_m1 = (top == 16'h0000) ? 16'h0000 : top - 16'h0001;
    assign wrap = (cnt_r == top_m1);

    // Waves allowed on the current breath level
    always_comb begin
      unique case (phase_r)
        pwb_pkg::PWB_RISE: lim = {8'h00, up_r};
        pwb_pkg::PWB_HOLD_HI: lim = hi_r;
        pwb_pkg::PWB_FALL: lim = {8'h00, dn_r};
        pwb_pkg::PWB_HOLD_LO: lim = lo_r;
      endcase
    end
    assign last = ({1'b0, rep_r} + 17'h00001) >= {1'b0, lim};

    // Duty in force: breath level, or the latched word
    always_comb begin
      duty_now = duty_r;
      if (mode == pwb_pkg::PWB_BREATH) begin
        unique case (phase_r)
          pwb_pkg::PWB_HOLD_HI: duty_now = {8'h00, step_r};
          pwb_pkg::PWB_HOLD_LO: duty_now = 16'h0000;
          default: duty_now = {8'h00, lvl_r};
        endcase
      end
    end

    // Only the FIFO owner in programmable mode asks for words
    assign want_pop[gi] = running_r & wrap & run & on &
                          (mode == pwb_pkg::PWB_PROG) &
                          (fsel_r == 4'(gi));

    // Period counter, run control and per-period duty update
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        running_r <= 1'b0;
        cnt_r <= 16'h0000;
        duty_r <= 16'h0000;
        phase_r <= pwb_pkg::PWB_RISE;
        lvl_r <= 8'h01;
        rep_r <= 16'h0000;
      end else if (!on || mode == pwb_pkg::PWB_RSVD) begin
        // Disable acts at once, mid period
        running_r <= 1'b0;
        cnt_r <= 16'h0000;
      end else if (!running_r) begin
        if (run) begin
          running_r <= 1'b1;
          cnt_r <= 16'h0000;
          duty_r <= (mode == pwb_pkg::PWB_FIXED) ? act_r : 16'h0000;
          phase_r <= pwb_pkg::PWB_RISE;
          lvl_r <= 8'h01;
          rep_r <= 16'h0000;
        end
      end else if (wrap) begin
        cnt_r <= 16'h0000;
        // Run cleared: stop only once the period is complete
        if (!run) begin
          running_r <= 1'b0;
        end
        if (mode == pwb_pkg::PWB_FIXED) begin
          duty_r <= act_r;
        end else if (mode == pwb_pkg::PWB_PROG) begin
          // Underrun keeps the old duty and raises the error flag
          if (want_pop[gi] & ~f_empty) begin
            duty_r <= f_head;
          end
        end else if (last) begin
          rep_r <= 16'h0000;
          unique case (phase_r)
            pwb_pkg::PWB_RISE: begin
              if (lvl_r >= step_r) begin
                phase_r <= pwb_pkg::PWB_HOLD_HI;
              end else begin
                lvl_r <= lvl_r + 8'h01;
              end
            end
            pwb_pkg::PWB_HOLD_HI: begin
              phase_r <= pwb_pkg::PWB_FALL;
              lvl_r <= step_r;
            end
            pwb_pkg::PWB_FALL: begin
              if (lvl_r <= 8'h01) begin
                phase_r <= pwb_pkg::PWB_HOLD_LO;
              end else begin
                lvl_r <= lvl_r - 8'h01;
              end
            end
            pwb_pkg::PWB_HOLD_LO: begin
              phase_r <= pwb_pkg::PWB_RISE;
              lvl_r <= 8'h01;
            end
          endcase
        end else begin
          rep_r <= rep_r + 16'h0001;
        end
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end

    // Active while the position is below the duty
    assign active = running_r & (cnt_r < duty_now);

    // Pin level; programmable mode ignores polarity
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        out_r <= 1'b1;
      end else if (mode == pwb_pkg::PWB_PROG) begin
        out_r <= active & on;
      end else begin
        out_r <= pol ? (active & on) : ~(active & on);
      end
    end
    assign pwm_out[gi] = out_r;
  end

endmodule
`default_nettype wire

// ### tb/pwb_properties.sv
// Bus, stream and pin checks for the nine-channel PWM block
`timescale 1ns/1ps
`default_nettype none
module pwb_properties (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic dma_valid,
  input wire logic [15:0] dma_data,
  input wire logic dma_ready,
  input wire logic [8:0] pwm_out
);
  logic start_r; // Copy of the fifo start bit, tracked from bus writes
  logic [4:0] ctl0_r; // Copy of channel 0 control
  logic wr_ctl0; // Lane 0 write to channel 0 control
  logic rd_ok; // Read answered in this cycle
  assign wr_ctl0 = avs_write && avs_address == 12'h000 && avs_byteenable[0];
  assign rd_ok = avs_read && !avs_waitrequest;
  // Start bit mirror; only lane 0 carries it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      start_r <= 1'b0;
    end else if (avs_write && avs_address == 12'hf00 &&
                 avs_byteenable[0]) begin
      start_r <= avs_writedata[0];
    end
  end
  // Control mirror for channel 0
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl0_r <= 5'h00;
    end else if (wr_ctl0) begin
      ctl0_r <= avs_writedata[4:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was held off");
  a_read_one_wait: assert property ($rose(avs_read) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer not after one wait");
  a_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
    else $error("wait raised without read");
  a_readdata_holds: assert property (!avs_read |=>
    $stable(avs_readdata))
    else $error("read data moved without read");
  a_ready_needs_start: assert property (!start_r |-> !dma_ready)
    else $error("stream ready while fill disabled");
  a_enable_stop_idle: assert property (wr_ctl0 && ctl0_r[3]
    && !avs_writedata[3] && avs_writedata[1:0] != 2'b10
    |-> ##[1:4] (pwm_out[0] == !ctl0_r[2]) [*4])
    else $error("channel 0 not idle after enable clear");
  a_ctl_reserved_zero: assert property (rd_ok && avs_address[7:0] == 8'h00
    && avs_address[11:8] <= 4'h8 |-> avs_readdata[31:5] == 27'h0)
    else $error("control reserved bits not zero");
  a_step_reserved_zero: assert property (rd_ok && avs_address[7:0] == 8'h04
    && avs_address[11:8] <= 4'h8 |-> avs_readdata[31:8] == 24'h0)
    else $error("step count reserved bits not zero");
  a_stat_reserved_zero: assert property (rd_ok && avs_address == 12'hf08
    |-> avs_readdata[31:5] == 27'h0)
    else $error("status reserved bits not zero");
  c_stream_beat: cover property (dma_valid && dma_ready);
  c_stream_stall: cover property (dma_valid && !dma_ready && start_r);
  c_read_done: cover property (rd_ok);
endmodule
`default_nettype wire

// ### tb/pwb_load_model.sv
// Lamp load model: counts lit cycles on each output pin
`timescale 1ns/1ps
`default_nettype none
module pwb_load_model (
  input wire logic ref_clk,
  input wire logic [8:0] pins,
  input wire logic clear,
  output logic [8:0][15:0] lit_cnt
);
  // A high pin drives current through the lamp; clear restarts the tally
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 9; i++) begin
      if (clear) begin
        lit_cnt[i] <= 16'h0000;
      end else begin
        lit_cnt[i] <= lit_cnt[i] + {15'h0000, pins[i]};
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/pwb_top_bench.sv
// Self-checking bench for the nine-channel PWM block
`timescale 1ns/1ps
`default_nettype none
module pwb_top_bench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic dma_valid = 1'b0;
  logic [15:0] dma_data = 16'h0;
  logic dma_ready;
  logic [8:0] pwm_out;
  logic clear = 1'b0;
  logic [8:0][15:0] lit_cnt;
  int mismatches = 0;
  int num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  pwb_top DUT (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dma_valid(dma_valid),
    .dma_data(dma_data), .dma_ready(dma_ready), .pwm_out(pwm_out));
  pwb_load_model load (.ref_clk(ref_clk), .pins(pwm_out), .clear(clear),
    .lit_cnt(lit_cnt));
  // Verdict and end of run
  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus write; writes are taken at the first edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    avs_write <= 1'b0;
    if (n == 50) begin
      mismatches++;
      test_done();
    end
  endtask
  // Bus read, compared against the expected word
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    int n;
    logic [31:0] d;
    @(posedge ref_clk);
    avs_read <= 1'b1;
    avs_address <= a;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    if (n == 50) begin
      mismatches++;
      test_done();
    end
    chk("readdata", d, exp);
  endtask
  // One stream beat, held until the block takes it
  task automatic push(input logic [15:0] w);
    int n;
    @(posedge ref_clk);
    dma_valid <= 1'b1;
    dma_data <= w;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (dma_ready === 1'b1) break;
    end
    dma_valid <= 1'b0;
    if (n == 50) begin
      mismatches++;
      test_done();
    end
  endtask
  // Lit cycles of one pin over a window that spans whole periods
  task automatic lit(input int ch, input int len, input logic [15:0] exp);
    @(posedge ref_clk);
    clear <= 1'b1;
    @(posedge ref_clk);
    clear <= 1'b0;
    repeat (len) @(posedge ref_clk);
    #1;
    chk("lit cycles", {16'h0, lit_cnt[ch]}, {16'h0, exp});
  endtask
  // Reset values, reserved bits, read-only word, unmapped place
  task automatic t_regs();
    rd(12'h000, 32'h0);
    rd(12'h304, 32'h20);
    rd(12'h814, 32'h1);
    rd(12'hf00, 32'h0);
    rd(12'hf08, 32'h14);
    rd(12'h900, 32'h0);
    wr(12'h208, 32'hffffffff);
    rd(12'h208, 32'h00ff00ff);
    wr(12'h700, 32'hffffffff);
    rd(12'h700, 32'h1f);
    wr(12'h700, 32'h0);
    wr(12'hf04, 32'h1234);
    rd(12'hf04, 32'h0);
  endtask
  // Two fixed channels of opposite polarity, then enable cut
  task automatic t_fixed();
    wr(12'h014, 32'ha);
    wr(12'h018, 32'h3);
    wr(12'h214, 32'ha);
    wr(12'h218, 32'h3);
    wr(12'h000, 32'h1c);
    wr(12'h200, 32'h18);
    repeat (30) @(posedge ref_clk);
    lit(0, 40, 16'd12);
    lit(2, 40, 16'd28);
    wr(12'h000, 32'h14);
    repeat (4) @(posedge ref_clk);
    lit(0, 20, 16'd0);
  endtask
  // Breath cycle: rise, high hold, fall, low hold with C of 4
  task automatic t_breath(input logic [7:0] up, input int len, exp);
    wr(12'h400, 32'h0);
    wr(12'h404, 32'h4);
    wr(12'h408, {8'h0, 8'h1, 8'h0, up});
    wr(12'h40c, 32'h1);
    wr(12'h410, 32'h1);
    wr(12'h400, 32'h1d);
    repeat (100) @(posedge ref_clk);
    lit(4, len, exp[15:0]);
  endtask
  // Stream-fed channel 6 beside fixed channel 2
  task automatic t_prog();
    wr(12'h614, 32'h8);
    wr(12'hf00, 32'h61);
    push(16'h3);
    push(16'h6);
    rd(12'hf08, 32'h02);
    @(posedge ref_clk);
    dma_valid <= 1'b1;
    dma_data <= 16'h7;
    repeat (3) @(posedge ref_clk);
    chk("ready while full", {31'h0, dma_ready}, 32'h0);
    // The stalled beat stays offered until the first pop frees a slot
    wr(12'h600, 32'h1a);
    push(16'h7);
    repeat (60) @(posedge ref_clk);
    lit(6, 32, 16'd28);
    lit(2, 40, 16'd28);
    rd(12'hf08, 32'h15);
    wr(12'h600, 32'h0a);
    repeat (20) @(posedge ref_clk);
    wr(12'hf08, 32'h1);
    rd(12'hf08, 32'h14);
    wr(12'h200, 32'h08);
    repeat (20) @(posedge ref_clk);
    lit(2, 20, 16'd20);
  endtask
  // Main sequence
  initial begin
    avs_byteenable = 4'hf;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    chk("reset pins", {23'h0, pwm_out}, 32'h1ff);
    t_regs();
    t_fixed();
    t_breath(8'h1, 80, 48);
    t_breath(8'h2, 112, 68);
    t_prog();
    test_done();
  end
endmodule
`default_nettype wire
bind pwb_top pwb_properties chk_i (.ref_clk(ref_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
  .pwm_out(pwm_out));
